//--- hdl/qib_regs.svh
// Timing constants and field widths for the quasi-ISA bus port
`ifndef QIB_REGS_SVH
`define QIB_REGS_SVH
`define QIB_ADDR_W        20
`define QIB_DATA_W        8
`define QIB_DMA_CH        4
`define QIB_CLK_NS        25
// Fixed command state length, in ns, for processor cycles; the strobe pin is low one clock less
// Long enough for a wait pulled after the slave's strobe sync to pass our own sync
`define QIB_CMD_NS        175
`define QIB_CMD_CYC       ((`QIB_CMD_NS + `QIB_CLK_NS - 1) / `QIB_CLK_NS)
// Address setup before strobe, in ns
`define QIB_SETUP_NS      25
`define QIB_SETUP_CYC     ((`QIB_SETUP_NS + `QIB_CLK_NS - 1) / `QIB_CLK_NS)
`define QIB_FIFO_DEPTH    4
`endif

//--- hdl/qib_pkg.sv
// Types shared by both ends of the quasi-ISA bus port
package qib_pkg;
   typedef enum logic [1:0] {
      QIB_CMD_MEM_RD = 2'b00,
      QIB_CMD_MEM_WR = 2'b01,
      QIB_CMD_IO_RD  = 2'b10,
      QIB_CMD_IO_WR  = 2'b11
   } qib_cmd_t;
   typedef enum logic [2:0] {
      QIB_ST_IDLE  = 3'b000,
      QIB_ST_SETUP = 3'b001,
      QIB_ST_STRB  = 3'b010,
      QIB_ST_HOLD  = 3'b011,
      QIB_ST_DONE  = 3'b100
   } qib_state_t;
endpackage

//--- hdl/qib_bus_if.sv
// Pin-level carrier between bus master and peripheral side
`timescale 1ns/1ps
`include "qib_regs.svh"
interface qib_bus_if;
   logic [`QIB_ADDR_W-1:0] sys_addr;
   logic [`QIB_DATA_W-1:0] sys_data_m;
   logic                   sys_data_m_oe;
   logic [`QIB_DATA_W-1:0] sys_data_s;
   logic                   sys_data_s_oe;
   logic                   addr_enable;
   logic                   io_write_n;
   logic                   io_read_n;
   logic                   mem_read_n;
   logic                   mem_write_n;
   logic                   ready_pull;
   logic [`QIB_DMA_CH-1:0] dma_request;
   logic [`QIB_DMA_CH-1:0] dma_ack_n;
   logic                   terminal_count;
   // Resolved wires; the wait line floats high when nobody pulls
   logic [`QIB_DATA_W-1:0] sys_data;
   logic                   ready;
   assign sys_data = sys_data_m_oe ? sys_data_m : (sys_data_s_oe ? sys_data_s : '1);
   assign ready    = ~ready_pull;
   modport master (
      output sys_addr, sys_data_m, sys_data_m_oe, addr_enable,
      output io_write_n, io_read_n, mem_read_n, mem_write_n,
      output dma_ack_n, terminal_count,
      input  sys_data, ready, dma_request
   );
   modport slave (
      input  sys_addr, sys_data, addr_enable,
      input  io_write_n, io_read_n, mem_read_n, mem_write_n,
      input  dma_ack_n, terminal_count,
      output sys_data_s, sys_data_s_oe, ready_pull, dma_request
   );
endinterface // qib_bus_if

//--- hdl/qib_fifo.sv
// Small valid/ready FIFO for read data
`timescale 1ns/1ps
module qib_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_q[rd_q];
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // qib_fifo

//--- hdl/qib_master.sv
// Device end: bus master issuing processor and DMA cycles
// What this block does
// [RULE1] Wait line high means ready, low stretches
// [RULE2] Only DMA cycles obey the wait line
// [RULE3] Processor cycles keep fixed length, ignore wait
// [RULE4] Slave pulls wait only after decode, strobe
// [RULE5] Slave releases wait after access ends; slave here releases it when wait_cycles runs out
// [RULE6] Requester holds request until its acknowledge
// [RULE7] Active-low acknowledge per channel grants bus
// [RULE8] Terminal count high marks transfer done
// [RULE9] Drive 20-bit system address
// [RULE10] 8-bit data both ways, writer drives; on DMA memory writes neither end drives
// [RULE11] Address enable low for I/O, high DMA
// [RULE12] I/O write strobe: slave latches data
// [RULE13] I/O read strobe: slave drives data
// [RULE14] Memory read strobe: slave drives data
// [RULE15] Memory write strobe: slave latches data
// [RULE16] One strobe per cycle, address held stable
`timescale 1ns/1ps
`include "qib_regs.svh"
module qib_master
   import qib_pkg::*;
(
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   // Processor request
   input  wire logic                   cpu_req_valid,
   output logic                        cpu_req_ready,
   input  wire qib_cmd_t               cpu_req_cmd,
   input  wire logic [`QIB_ADDR_W-1:0] cpu_req_addr,
   input  wire logic [`QIB_DATA_W-1:0] cpu_req_wdata,
   // DMA request from the internal controller
   input  wire logic                   dma_go,
   input  wire logic                   dma_to_mem,
   input  wire logic [`QIB_ADDR_W-1:0] dma_addr,
   input  wire logic                   dma_last,
   output logic [`QIB_DMA_CH-1:0]      dma_pending,
   output logic                        dma_busy,
   // Read data out
   output logic                        rd_valid,
   input  wire logic                   rd_ready,
   output logic [`QIB_DATA_W-1:0]      rd_data,
   // Bus
   qib_bus_if.master                   bus
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic       rdy_s1_q;
   logic       rdy_s2_q;
   logic [3:0] drq_s1_q;
   logic [3:0] drq_s2_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdy_s1_q <= 1'b1;
         rdy_s2_q <= 1'b1;
         drq_s1_q <= '0;
         drq_s2_q <= '0;
      end else begin
         rdy_s1_q <= bus.ready;
         rdy_s2_q <= rdy_s1_q;
         drq_s1_q <= bus.dma_request;
         drq_s2_q <= drq_s1_q;
      end
   end
   assign dma_pending = drq_s2_q;

   // ==========================================================
   // Cycle sequencer
   // ==========================================================
   qib_state_t             st_q;
   logic [3:0]             cnt_q;
   qib_cmd_t               cmd_q;
   logic                   is_dma_q;
   logic                   last_q;
   logic [1:0]             ch_q;
   logic [`QIB_ADDR_W-1:0] addr_q;
   logic [`QIB_DATA_W-1:0] wdat_q;
   logic                   fifo_in_ready;
   logic                   cap_q;
   logic                   dma_pick;
   logic [1:0]             pick_ch;
   always_comb begin
      pick_ch = 2'd0;
      for (int i = `QIB_DMA_CH - 1; i >= 0; i--) begin
         if (drq_s2_q[i]) begin
            pick_ch = 2'(i);
         end
      end
   end
   // DMA wins over the processor when both are waiting
   assign dma_pick      = dma_go & (|drq_s2_q);
   assign cpu_req_ready = (st_q == QIB_ST_IDLE) & ~dma_pick & fifo_in_ready;
   assign dma_busy      = is_dma_q & (st_q != QIB_ST_IDLE);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_q     <= QIB_ST_IDLE;
         cnt_q    <= '0;
         cmd_q    <= QIB_CMD_MEM_RD;
         is_dma_q <= 1'b0;
         last_q   <= 1'b0;
         ch_q     <= '0;
         addr_q   <= '0;
         wdat_q   <= '0;
      end else begin
         case (st_q)
            QIB_ST_IDLE: begin
               cnt_q <= 4'(`QIB_SETUP_CYC);
               if (dma_pick && fifo_in_ready) begin
                  st_q     <= QIB_ST_SETUP;
                  is_dma_q <= 1'b1;
                  last_q   <= dma_last;
                  ch_q     <= pick_ch;
                  addr_q   <= dma_addr;
                  // Memory side of a DMA pair; device-to-memory writes memory
                  cmd_q    <= dma_to_mem ? QIB_CMD_MEM_WR : QIB_CMD_MEM_RD;
               end else if (cpu_req_valid && cpu_req_ready) begin
                  st_q     <= QIB_ST_SETUP;
                  is_dma_q <= 1'b0;
                  last_q   <= 1'b0;
                  addr_q   <= cpu_req_addr;
                  wdat_q   <= cpu_req_wdata;
                  cmd_q    <= cpu_req_cmd;
               end
            end
            QIB_ST_SETUP: begin
               if (cnt_q <= 4'd1) begin
                  st_q  <= QIB_ST_STRB;
                  cnt_q <= 4'(`QIB_CMD_CYC);
               end else begin
                  cnt_q <= cnt_q - 4'd1;
               end
            end
            QIB_ST_STRB: begin
               if (cnt_q > 4'd1) begin
                  cnt_q <= cnt_q - 4'd1;
               // [RULE2] DMA stretch by wait
               end else if (is_dma_q && !rdy_s2_q) begin
                  cnt_q <= cnt_q;
               // [RULE3] Processor ignores wait
               end else begin
                  st_q <= QIB_ST_HOLD;
               end
            end
            QIB_ST_HOLD: begin
               st_q <= QIB_ST_DONE;
            end
            QIB_ST_DONE: begin
               st_q <= QIB_ST_IDLE;
            end
            default: begin
               st_q <= QIB_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Pin drivers, registered except address enable
   // ==========================================================
   logic       strobe_on;
   logic [3:0] strb_n_q;
   assign strobe_on = (st_q == QIB_ST_STRB);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         strb_n_q <= 4'hf;
         cap_q    <= 1'b0;
      end else begin
         // [RULE16] Single strobe only
         strb_n_q <= 4'hf;
         if (strobe_on && !(cnt_q <= 4'd1 && (!is_dma_q || rdy_s2_q))) begin
            strb_n_q[cmd_q] <= 1'b0;
         end
         // Sample read data on the strobe's last cycle
         cap_q <= strobe_on & (cnt_q <= 4'd1) & (!is_dma_q | rdy_s2_q)
                  & ((cmd_q == QIB_CMD_MEM_RD) | (cmd_q == QIB_CMD_IO_RD));
      end
   end
   // [RULE14] Memory read strobe
   assign bus.mem_read_n  = strb_n_q[QIB_CMD_MEM_RD];
   // [RULE15] Memory write strobe
   assign bus.mem_write_n = strb_n_q[QIB_CMD_MEM_WR];
   // [RULE13] I/O read strobe
   assign bus.io_read_n   = strb_n_q[QIB_CMD_IO_RD];
   // [RULE12] I/O write strobe
   assign bus.io_write_n  = strb_n_q[QIB_CMD_IO_WR];
   // [RULE9] Address held from setup to done
   assign bus.sys_addr    = addr_q;
   // [RULE11] High only during DMA
   assign bus.addr_enable = dma_busy;

   logic [3:0] ack_n_q;
   logic       tc_q;
   logic       doe_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_n_q <= 4'hf;
         tc_q    <= 1'b0;
         doe_q   <= 1'b0;
      end else begin
         ack_n_q <= 4'hf;
         // [RULE7] Grant one channel
         if (st_q == QIB_ST_SETUP || st_q == QIB_ST_STRB || st_q == QIB_ST_HOLD) begin
            if (is_dma_q) begin
               ack_n_q[ch_q] <= 1'b0;
            end
         end
         // [RULE8] Terminal count
         tc_q  <= is_dma_q & last_q & strobe_on;
         // [RULE10] Drive data on processor writes
         doe_q <= ~is_dma_q & (st_q != QIB_ST_IDLE) & (st_q != QIB_ST_DONE)
                  & ((cmd_q == QIB_CMD_MEM_WR) | (cmd_q == QIB_CMD_IO_WR));
      end
   end
   assign bus.dma_ack_n      = ack_n_q;
   assign bus.terminal_count = tc_q;
   assign bus.sys_data_m     = wdat_q;
   assign bus.sys_data_m_oe  = doe_q;

   // ==========================================================
   // Read data buffer; full FIFO stalls new cycles
   // ==========================================================
   logic [`QIB_DATA_W-1:0] din_s1_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         din_s1_q <= '0;
      end else begin
         din_s1_q <= bus.sys_data;
      end
   end
   qib_fifo #(
      .WIDTH (`QIB_DATA_W),
      .DEPTH (`QIB_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .in_valid  (cap_q & ~is_dma_q),
      .in_ready  (fifo_in_ready),
      .in_data   (din_s1_q),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );
endmodule // qib_master

//--- hdl/qib_slave.sv
// Far end: memory/I/O slave with wait and DMA requester
`timescale 1ns/1ps
`include "qib_regs.svh"
module qib_slave
   import qib_pkg::*;
(
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   // User side
   input  wire logic [3:0]             want_dma,
   input  wire logic [3:0]             wait_cycles,
   output logic [`QIB_ADDR_W-1:0]      last_addr,
   output logic [`QIB_DATA_W-1:0]      last_wdata,
   output logic                        wr_seen,
   output logic                        tc_seen,
   // Bus
   qib_bus_if.slave                    bus
);
   // ==========================================================
   // Synchronise strobes
   // ==========================================================
   logic [3:0] cmd_s1_q;
   logic [3:0] cmd_s2_q;
   logic [3:0] dack_s1_q;
   logic [3:0] dack_s2_q;
   logic       tc_s1_q;
   logic       tc_s2_q;
   logic       aen_s1_q;
   logic       aen_s2_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_s1_q  <= 4'hf;
         cmd_s2_q  <= 4'hf;
         dack_s1_q <= 4'hf;
         dack_s2_q <= 4'hf;
         tc_s1_q   <= 1'b0;
         tc_s2_q   <= 1'b0;
         aen_s1_q  <= 1'b0;
         aen_s2_q  <= 1'b0;
      end else begin
         cmd_s1_q  <= {bus.io_write_n, bus.io_read_n, bus.mem_write_n, bus.mem_read_n};
         cmd_s2_q  <= cmd_s1_q;
         dack_s1_q <= bus.dma_ack_n;
         dack_s2_q <= dack_s1_q;
         tc_s1_q   <= bus.terminal_count;
         tc_s2_q   <= tc_s1_q;
         aen_s1_q  <= bus.addr_enable;
         aen_s2_q  <= aen_s1_q;
      end
   end
   logic active;
   logic io_ok;
   assign active = ~&cmd_s2_q;
   // [RULE11] I/O answered only when enable low
   assign io_ok  = ~aen_s2_q;

   // ==========================================================
   // Wait, data and request handling
   // ==========================================================
   logic [3:0] wcnt_q;
   logic       pull_q;
   logic       act_d1_q;
   logic       doe_q;
   logic [3:0] drq_q;
   logic       wr_cyc_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_cyc_q   <= 1'b0;
         wcnt_q     <= '0;
         pull_q     <= 1'b0;
         act_d1_q   <= 1'b0;
         doe_q      <= 1'b0;
         drq_q      <= '0;
         last_addr  <= '0;
         last_wdata <= '0;
         wr_seen    <= 1'b0;
         tc_seen    <= 1'b0;
      end else begin
         act_d1_q <= active;
         wr_seen  <= 1'b0;
         // [RULE4] Pull wait after strobe seen
         if (active && !act_d1_q && wait_cycles != 4'd0) begin
            pull_q <= 1'b1;
            wcnt_q <= wait_cycles;
         end else if (wcnt_q > 4'd1) begin
            wcnt_q <= wcnt_q - 4'd1;
         // [RULE5] Release when done
         end else begin
            wcnt_q <= '0;
            pull_q <= 1'b0;
         end
         // [RULE13] [RULE14] Drive data on read strobes
         doe_q <= ~cmd_s2_q[0] | (~cmd_s2_q[2] & io_ok);
         // [RULE12] [RULE15] Latch data at write strobe end
         if (act_d1_q && !active) begin
            last_addr <= bus.sys_addr;
         end
         // Data stands all through the strobe; report once at its end
         if (!cmd_s2_q[1] || (!cmd_s2_q[3] && io_ok)) begin
            last_wdata <= bus.sys_data;
            wr_cyc_q   <= 1'b1;
         end else if (!active) begin
            wr_cyc_q   <= 1'b0;
         end
         if (act_d1_q && !active && wr_cyc_q) begin
            wr_seen <= 1'b1;
         end
         // [RULE6] Hold request until acknowledge
         for (int i = 0; i < `QIB_DMA_CH; i++) begin
            if (want_dma[i]) begin
               drq_q[i] <= 1'b1;
            end else if (!dack_s2_q[i]) begin
               drq_q[i] <= 1'b0;
            end
         end
         tc_seen <= tc_s2_q;
      end
   end
   // [RULE1] Low ready stretches cycle
   assign bus.ready_pull    = pull_q;
   assign bus.sys_data_s    = bus.sys_addr[`QIB_DATA_W-1:0];
   // [RULE10] Slave drives only on reads
   assign bus.sys_data_s_oe = doe_q;
   assign bus.dma_request   = drq_q;
endmodule // qib_slave

//--- dv/qib_assertions.sv
// Concurrent checks on the wires between bus master and slave
`timescale 1ns/1ps
`include "qib_regs.svh"
module qib_assertions (
   // Clock and reset
   input wire logic                   sys_clk,
   input wire logic                   nrst,
   // Address, data drivers, strobes
   input wire logic [`QIB_ADDR_W-1:0] sys_addr,
   input wire logic                   sys_data_m_oe,
   input wire logic                   sys_data_s_oe,
   input wire logic                   addr_enable,
   input wire logic                   io_write_n,
   input wire logic                   io_read_n,
   input wire logic                   mem_read_n,
   input wire logic                   mem_write_n,
   // Wait and DMA handshake
   input wire logic                   ready,
   input wire logic [`QIB_DMA_CH-1:0] dma_ack_n,
   input wire logic                   terminal_count
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   logic strb_low;
   logic ack_low;
   assign strb_low = ~(io_write_n & io_read_n & mem_read_n & mem_write_n);
   assign ack_low  = (dma_ack_n != 4'hf);

   // ==========================================
   // Cycle shapes
   sequence cpu_start_s;
      $rose(strb_low) && !addr_enable;
   endsequence
   sequence fixed_len_s;
      strb_low [*6] ##1 !strb_low;
   endsequence
   // Three cycles of wait seen inside a DMA strobe
   sequence dma_wait_s;
      (strb_low && addr_enable && !ready) [*3];
   endsequence

   cpu_fixed_len_a: assert property (cpu_start_s |-> fixed_len_s)
      else $error("processor strobe length not fixed");
   dma_stretch_a: assert property (dma_wait_s |=> strb_low)
      else $error("DMA strobe ended while wait held low");
   one_strobe_a: assert property ($onehot0(~{io_write_n, io_read_n, mem_read_n, mem_write_n}))
      else $error("more than one command strobe low");
   addr_stable_a: assert property (strb_low && $past(strb_low) |-> $stable(sys_addr))
      else $error("address moved under a strobe");
   ack_onehot_a: assert property ($onehot0(~dma_ack_n))
      else $error("more than one acknowledge low");
   dma_aen_high_a: assert property (strb_low && ack_low |-> addr_enable && io_read_n && io_write_n)
      else $error("DMA cycle without address enable high");
   cpu_aen_low_a: assert property (strb_low && !addr_enable |-> !ack_low)
      else $error("acknowledge low in processor cycle");
   tc_in_dma_a: assert property (terminal_count |-> addr_enable && ack_low)
      else $error("terminal count outside DMA cycle");
   write_drive_a: assert property (!io_write_n || (!mem_write_n && !addr_enable) |-> sys_data_m_oe)
      else $error("master not driving data on write");
   read_release_a: assert property (!io_read_n || !mem_read_n |-> !sys_data_m_oe)
      else $error("master driving data on read");
   one_driver_a: assert property (!(sys_data_m_oe && sys_data_s_oe))
      else $error("both ends drive the data bus");
endmodule // qib_assertions

//--- dv/qib_test.sv
// Self-checking bench joining master and slave over the bus carrier
`timescale 1ns/1ps
`include "qib_regs.svh"
module qib_test
   import qib_pkg::*;
;
   typedef struct {
      logic                   is_wr;
      logic [`QIB_ADDR_W-1:0] addr;
      logic [`QIB_DATA_W-1:0] data;
   } qib_note_t;

   logic                   sys_clk = 1'b0;
   logic                   nrst;
   logic                   cpu_req_valid;
   logic                   cpu_req_ready;
   qib_cmd_t               cpu_req_cmd;
   logic [`QIB_ADDR_W-1:0] cpu_req_addr;
   logic [`QIB_DATA_W-1:0] cpu_req_wdata;
   logic                   dma_go;
   logic                   dma_to_mem;
   logic [`QIB_ADDR_W-1:0] dma_addr;
   logic                   dma_last;
   logic                   dma_busy;
   logic                   rd_valid;
   logic                   rd_ready;
   logic [`QIB_DATA_W-1:0] rd_data;
   logic [3:0]             want_dma;
   logic [3:0]             wait_cycles;
   logic [`QIB_ADDR_W-1:0] last_addr;
   logic [`QIB_DATA_W-1:0] last_wdata;
   logic                   wr_seen;
   logic                   tc_seen;
   logic                   in_dma;
   logic                   ok;
   logic                   tc_hit;
   qib_note_t              notes[$];
   qib_note_t              nt;
   int                     error_cnt = 0;
   int                     checked = 0;
   int                     i;
   int                     k;
   int                     n;

   always #12.5 sys_clk = ~sys_clk;

   qib_bus_if qib_bus_if_inst ();
   qib_master qib_master_inst (
      .sys_clk(sys_clk), .nrst(nrst), .cpu_req_valid(cpu_req_valid),
      .cpu_req_ready(cpu_req_ready), .cpu_req_cmd(cpu_req_cmd), .cpu_req_addr(cpu_req_addr),
      .cpu_req_wdata(cpu_req_wdata), .dma_go(dma_go), .dma_to_mem(dma_to_mem),
      .dma_addr(dma_addr), .dma_last(dma_last), .dma_pending(), .dma_busy(dma_busy),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .bus(qib_bus_if_inst));
   qib_slave qib_slave_inst (
      .sys_clk(sys_clk), .nrst(nrst), .want_dma(want_dma), .wait_cycles(wait_cycles),
      .last_addr(last_addr), .last_wdata(last_wdata), .wr_seen(wr_seen), .tc_seen(tc_seen),
      .bus(qib_bus_if_inst));
   qib_assertions qib_assertions_inst (
      .sys_clk(sys_clk), .nrst(nrst), .sys_addr(qib_bus_if_inst.sys_addr),
      .sys_data_m_oe(qib_bus_if_inst.sys_data_m_oe),
      .sys_data_s_oe(qib_bus_if_inst.sys_data_s_oe),
      .addr_enable(qib_bus_if_inst.addr_enable), .io_write_n(qib_bus_if_inst.io_write_n),
      .io_read_n(qib_bus_if_inst.io_read_n), .mem_read_n(qib_bus_if_inst.mem_read_n),
      .mem_write_n(qib_bus_if_inst.mem_write_n), .ready(qib_bus_if_inst.ready),
      .dma_ack_n(qib_bus_if_inst.dma_ack_n),
      .terminal_count(qib_bus_if_inst.terminal_count));

   // ==========================================
   // Shared tasks
   task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task complete_run;
      $display("Counts: %0d compared, %0d mismatched", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task to_fail(string what);
      error_cnt++;
      $display("BAD %s expected done seen timeout", what);
      complete_run();
   endtask

   // Inputs move a fixed 2 ns after the edge
   task step;
      @(posedge sys_clk);
      #2;
   endtask

   // Offer one processor request; taken only on an edge with ready high
   task automatic cpu_op(qib_cmd_t cmd, logic [19:0] a, logic [7:0] d, output logic took);
      took = 1'b0;
      cpu_req_cmd = cmd;
      cpu_req_addr = a;
      cpu_req_wdata = d;
      cpu_req_valid = 1'b1;
      for (int j = 0; j < 40 && !took; j++) begin
         @(posedge sys_clk);
         took = cpu_req_ready;
      end
      #2;
      cpu_req_valid = 1'b0;
      if (took)
         notes.push_back('{cmd[0], a, cmd[0] ? d : a[7:0]});
      // Let an edge pass so a following call never raises valid in this time step
      step();
   endtask

   task wait_notes;
      for (i = 0; i < 200 && notes.size() != 0; i++)
         step();
      if (notes.size() != 0)
         to_fail("result queue drain");
   endtask

   // ==========================================
   // Result watcher: oldest note against each result
   always @(posedge sys_clk) begin
      if (nrst && ((rd_valid && rd_ready) || (wr_seen && !in_dma))) begin
         if (notes.size() == 0) begin
            chk("unexpected result", 20'h0, 20'h1);
         end else begin
            nt = notes.pop_front();
            chk("result kind", {19'h0, nt.is_wr}, {19'h0, wr_seen});
            if (wr_seen) begin
               chk("write address", nt.addr, last_addr);
               chk("write data", {12'h0, nt.data}, {12'h0, last_wdata});
            end else begin
               chk("read data", {12'h0, nt.data}, {12'h0, rd_data});
            end
         end
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(32'hdc788acf));
      nrst = 1'b0;
      cpu_req_valid = 1'b0;
      cpu_req_cmd = QIB_CMD_MEM_RD;
      cpu_req_addr = 20'h0;
      cpu_req_wdata = 8'h0;
      dma_go = 1'b0;
      dma_to_mem = 1'b0;
      dma_addr = 20'h0;
      dma_last = 1'b0;
      rd_ready = 1'b1;
      want_dma = 4'h0;
      wait_cycles = 4'h0;
      in_dma = 1'b0;
      repeat (2) @(posedge sys_clk);
      #2;
      nrst = 1'b1;
      step();
      // Every command, slave asking for waits the processor must ignore
      for (k = 0; k < 16; k++) begin
         wait_cycles = 4'(1 + $urandom_range(0, 6));
         cpu_op(qib_cmd_t'(k[1:0]), 20'($urandom), 8'($urandom), ok);
         chk("processor take", 20'h1, {19'h0, ok});
      end
      wait_notes();
      $display("Test processor cycles finished");
      // Reads with drain stalled: buffer fills, then refuses
      rd_ready = 1'b0;
      n = 0;
      for (k = 0; k < 5; k++) begin
         cpu_op(QIB_CMD_IO_RD, 20'($urandom), 8'h0, ok);
         n += int'(ok);
      end
      chk("reads taken while full", 20'(`QIB_FIFO_DEPTH), 20'(n));
      rd_ready = 1'b1;
      wait_notes();
      $display("Test buffer fill and drain finished");
      // One DMA cycle per channel, slave stretching it
      in_dma = 1'b1;
      for (k = 0; k < 4; k++) begin
         want_dma = 4'h1 << k;
         wait_cycles = 4'h3;
         dma_to_mem = k[0];
         dma_addr = 20'($urandom);
         dma_last = (k == 3);
         dma_go = 1'b1;
         for (i = 0; i < 40 && !dma_busy; i++)
            step();
         if (!dma_busy)
            to_fail("DMA start");
         dma_go = 1'b0;
         // Slave keeps its request until it sees the acknowledge
         want_dma = 4'h0;
         for (i = 0; i < 20 && qib_bus_if_inst.mem_read_n && qib_bus_if_inst.mem_write_n; i++)
            step();
         chk("acknowledge", {16'h0, ~(4'h1 << k)}, {16'h0, qib_bus_if_inst.dma_ack_n});
         chk("address enable", 20'h1, {19'h0, qib_bus_if_inst.addr_enable});
         chk("DMA address", dma_addr, qib_bus_if_inst.sys_addr);
         tc_hit = 1'b0;
         for (n = 0; n < 40 && !(qib_bus_if_inst.mem_read_n && qib_bus_if_inst.mem_write_n); n++) begin
            tc_hit |= tc_seen;
            step();
         end
         chk("terminal count seen", {19'h0, k == 3}, {19'h0, tc_hit});
         chk("DMA stretched", 20'h1, {19'h0, n > (`QIB_CMD_CYC - 1)});
         for (i = 0; i < 40 && dma_busy; i++)
            step();
         if (dma_busy)
            to_fail("DMA end");
         repeat (4) step();
      end
      in_dma = 1'b0;
      $display("Test DMA channels finished");
      // Second reset mid-run, then one write
      nrst = 1'b0;
      step();
      notes.delete();
      nrst = 1'b1;
      step();
      cpu_op(QIB_CMD_MEM_WR, 20'hf00a5, 8'h5a, ok);
      chk("take after reset", 20'h1, {19'h0, ok});
      wait_notes();
      $display("Test second reset finished");
      complete_run();
   end
endmodule // qib_test
